// ==== rtl/ddi_pkg.sv ====
// Constants, codes and timing counts shared by the injection device end and the debugger end.
// Assumes both ends run on the one system clock clk_sys at 200 MHz.
// Function
// - Mode 00 enters injection after burst preempt
// - Debugger enters injection only from halt/step
// - Injection forces debug status view, register untouched
// - Visible state frozen while injecting
// - Only data/coprocessor exceptions taken, not option 110
// - Status outputs show 010 while injecting
// - Hold register follows instruction bus each cycle
// - Leave injection two cycles later, 10/01 only
// - Exit to step marks valid; halt discards
// - Injected instruction reruns every step
// - Option 110 access completes at next step
// - No conditional jumps, multiples or returns injected
// - Separate injected loads and stores by another
// - Injected code leaves counters, channel, ALU status
// - Injected code may reach protected state
// - Normal data access completes before step ends
// - Resume by stepping return, then 10, 11
// - Wait for 010, load, then select step
// - Step 01-11-01, hold load data until done
// - Test input floats all outputs but error
// - Test mode needs an external clock
// - 01 to 11 advances one stage, back to step
// - Mode 10 halts after data access completes
package ddi_pkg;
   localparam int INSTR_W = 32;
   localparam int DATA_W = 32;
   localparam int MODE_W = 2;
   localparam int STAT_W = 3;
   localparam int OPT_W = 3;
   localparam logic [MODE_W-1:0] MODE_INJECT = 2'h0;
   localparam logic [MODE_W-1:0] MODE_STEP = 2'h1;
   localparam logic [MODE_W-1:0] MODE_HALT = 2'h2;
   localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h3;
   localparam logic [STAT_W-1:0] STAT_HALTSTEP = 3'h0;
   localparam logic [STAT_W-1:0] STAT_HOLD = 3'h1;
   localparam logic [STAT_W-1:0] STAT_INJECT = 3'h2;
   localparam logic [STAT_W-1:0] STAT_EXEC = 3'h3;
   localparam logic [STAT_W-1:0] STAT_STEPLAST = 3'h4;
   localparam int STAT_LAST_BIT = 2;
   localparam logic [OPT_W-1:0] OPT_DEBUGGER = 3'h6;
   localparam logic [INSTR_W-1:0] INSTR_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
   // Debugger register map (byte addresses) and fields
   localparam int APB_AW = 4;
   localparam logic [APB_AW-1:0] ADDR_CTRL = 4'h0;
   localparam logic [APB_AW-1:0] ADDR_INSTR = 4'h4;
   localparam logic [APB_AW-1:0] ADDR_LDATA = 4'h8;
   localparam logic [APB_AW-1:0] ADDR_STATUS = 4'hc;
   localparam int CTRL_CMD_LSB = 0;
   localparam int CTRL_CMD_W = 2;
   localparam int CTRL_TEST_BIT = 4;
   localparam int CTRL_LDRV_BIT = 5;
   localparam logic [CTRL_CMD_W-1:0] CMD_NONE = 2'h0;
   localparam logic [CTRL_CMD_W-1:0] CMD_HALT = 2'h1;
   localparam logic [CTRL_CMD_W-1:0] CMD_INJECT_STEP = 2'h2;
   localparam logic [CTRL_CMD_W-1:0] CMD_RESUME = 2'h3;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_HALTED_BIT = 1;
   localparam int STATUS_REFUSED_BIT = 2;
   localparam int STATUS_STAT_LSB = 4;
   // Hold time of an instruction on the bus before step is selected
   localparam int LOAD_TIME_NS = 15;
   localparam int CLK_PERIOD_NS = 5;
   localparam int LOAD_CYC = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_CNT_W = 3;
endpackage : ddi_pkg

// ==== rtl/ddi_link_if.sv ====
// Pin-level link between the injection device end and the debugger end.
// Assumes the testbench drives dataRdy and dataErr as the external memory system.
interface ddi_link_if;
   import ddi_pkg::*;
   logic [MODE_W-1:0] modeCtl;
   logic [INSTR_W-1:0] instrBus;
   logic instrOe;
   logic [DATA_W-1:0] hostData;
   logic hostDataOe;
   logic dataRdy;
   logic dataErr;
   logic [STAT_W-1:0] stat;
   logic statOe;
   logic master_slave_error_output;
   logic testActN;
   modport dev (
      input modeCtl,
      input instrBus,
      input instrOe,
      input dataRdy,
      input dataErr,
      input testActN,
      output stat,
      output statOe,
      output master_slave_error_output
   );
   modport dbg (
      output modeCtl,
      output instrBus,
      output instrOe,
      output hostData,
      output hostDataOe,
      output testActN,
      input stat,
      input statOe
   );
endinterface : ddi_link_if

// ==== rtl/ddi_device.sv ====
// Instruction-injection mode logic of the processor: mode decode, hold register, step sequencing.
// Assumes the core reports bursts, data accesses and exceptions on the user side on clk_sys.
module ddi_device
   import ddi_pkg::*;
#(
   parameter int IW = INSTR_W
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   ddi_link_if.dev link,
   input wire logic burstEstablished,
   input wire logic dataAccessBusy,
   input wire logic accessStart,
   input wire logic [OPT_W-1:0] accessOpt,
   input wire logic excDataAccess,
   input wire logic excCoproc,
   input wire logic excOther,
   input wire logic msErrIn,
   output logic [IW-1:0] irOut,
   output logic irValid,
   output logic pipeAdvance,
   output logic burstPreempt,
   output logic debugPsrForce,
   output logic stateFreeze,
   output logic specialInhibit,
   output logic privOverride,
   output logic excTake,
   output logic optAccessDone
);
   typedef enum {S_EXEC, S_HALT, S_STEP, S_RUN, S_LAST, S_INJECT} ddi_dev_state_t;

   function automatic logic [STAT_W-1:0] statFor(input ddi_dev_state_t s);
      logic [STAT_W-1:0] v;
      v = STAT_HALTSTEP;
      unique case (s)
         S_EXEC: v = STAT_EXEC;
         S_HALT, S_STEP: v = STAT_HALTSTEP;
         S_RUN: v = STAT_HOLD;
         S_LAST: v = STAT_STEPLAST;
         S_INJECT: v = STAT_INJECT;
      endcase
      return v;
   endfunction : statFor

   // Mode, data response synchronisers
   logic [MODE_W-1:0] modeS1_reg, modeS2_reg, modePrev_reg;
   logic rdyS1_reg, rdyS2_reg, errS1_reg, errS2_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         modeS1_reg <= MODE_HALT;
         modeS2_reg <= MODE_HALT;
         modePrev_reg <= MODE_HALT;
         rdyS1_reg <= 1'b0;
         rdyS2_reg <= 1'b0;
         errS1_reg <= 1'b0;
         errS2_reg <= 1'b0;
      end else if (ce) begin
         modeS1_reg <= link.modeCtl;
         modeS2_reg <= modeS1_reg;
         modePrev_reg <= modeS2_reg;
         rdyS1_reg <= link.dataRdy;
         rdyS2_reg <= rdyS1_reg;
         errS1_reg <= link.dataErr;
         errS2_reg <= errS1_reg;
      end
   end

   ddi_dev_state_t st_reg, st_next;
   logic [IW-1:0] ir_reg, ir_next;
   logic irv_reg, irv_next;
   logic adv_reg, adv_next;
   logic pre_reg, pre_next;
   logic psr_reg, psr_next;
   logic wait_reg, wait_next;
   logic optPend_reg, optPend_next;
   logic optDone_reg, optDone_next;
   logic exc_reg, exc_next;
   logic [STAT_W-1:0] stat_reg, stat_next;
   logic master_slave_error_output_reg;
   logic normalAcc, runDone, enterInject;

   always_comb begin
      st_next = st_reg;
      ir_next = ir_reg;
      irv_next = irv_reg;
      adv_next = 1'b0;
      pre_next = 1'b0;
      psr_next = psr_reg;
      wait_next = wait_reg;
      optPend_next = optPend_reg;
      optDone_next = 1'b0;
      normalAcc = accessStart && (accessOpt != OPT_DEBUGGER);
      runDone = (!normalAcc && !wait_reg) || rdyS2_reg || errS2_reg;
      enterInject = (modeS2_reg == MODE_INJECT);
      // Exceptions: in debug view only data access and coprocessor, never for option 110
      if (psr_reg) begin
         exc_next = (excDataAccess || excCoproc || (st_reg == S_RUN && wait_reg && errS2_reg))
            && (accessOpt != OPT_DEBUGGER);
      end else begin
         exc_next = excDataAccess || excCoproc || excOther || (st_reg == S_RUN && wait_reg && errS2_reg);
      end
      unique case (st_reg)
         S_EXEC: begin
            if (modeS2_reg == MODE_HALT && !dataAccessBusy) begin
               st_next = S_HALT;
            end else if (modeS2_reg == MODE_STEP && !dataAccessBusy) begin
               st_next = S_STEP;
            end
         end
         S_HALT: begin
            if (enterInject) begin
               pre_next = burstEstablished;
               psr_next = 1'b1;
               st_next = S_INJECT;
            end else if (modeS2_reg == MODE_NORMAL) begin
               psr_next = 1'b0;
               irv_next = 1'b0;
               st_next = S_EXEC;
            end
         end
         S_STEP: begin
            if (enterInject) begin
               pre_next = burstEstablished;
               psr_next = 1'b1;
               st_next = S_INJECT;
            end else if (modeS2_reg == MODE_NORMAL && modePrev_reg == MODE_STEP) begin
               adv_next = 1'b1;
               optDone_next = optPend_reg;
               optPend_next = 1'b0;
               st_next = S_RUN;
            end else if (modeS2_reg == MODE_HALT) begin
               st_next = S_HALT;
            end
         end
         S_RUN: begin
            if (accessStart && accessOpt == OPT_DEBUGGER) begin
               optPend_next = 1'b1;
            end
            if (runDone) begin
               wait_next = 1'b0;
               st_next = S_LAST;
            end else begin
               wait_next = 1'b1;
            end
         end
         S_LAST: begin
            st_next = S_STEP;
         end
         S_INJECT: begin
            ir_next = link.instrBus;
            if (modeS2_reg == MODE_STEP) begin
               irv_next = 1'b1;
               st_next = S_STEP;
            end else if (modeS2_reg == MODE_HALT) begin
               irv_next = 1'b0;
               st_next = S_HALT;
            end
         end
      endcase
      stat_next = statFor(st_next);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg <= S_HALT;
         ir_reg <= INSTR_RESET;
         irv_reg <= 1'b0;
         adv_reg <= 1'b0;
         pre_reg <= 1'b0;
         psr_reg <= 1'b0;
         wait_reg <= 1'b0;
         optPend_reg <= 1'b0;
         optDone_reg <= 1'b0;
         exc_reg <= 1'b0;
         stat_reg <= STAT_HALTSTEP;
         master_slave_error_output_reg <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
         ir_reg <= ir_next;
         irv_reg <= irv_next;
         adv_reg <= adv_next;
         pre_reg <= pre_next;
         psr_reg <= psr_next;
         wait_reg <= wait_next;
         optPend_reg <= optPend_next;
         optDone_reg <= optDone_next;
         exc_reg <= exc_next;
         stat_reg <= stat_next;
         master_slave_error_output_reg <= msErrIn;
      end
   end

   logic freeze_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         freeze_reg <= 1'b0;
      end else if (ce) begin
         freeze_reg <= (st_next == S_INJECT);
      end
   end

   assign irOut = ir_reg;
   assign irValid = irv_reg;
   assign pipeAdvance = adv_reg;
   assign burstPreempt = pre_reg;
   assign debugPsrForce = psr_reg;
   assign stateFreeze = freeze_reg;
   assign specialInhibit = psr_reg;
   assign privOverride = psr_reg;
   assign excTake = exc_reg;
   assign optAccessDone = optDone_reg;
   assign link.stat = stat_reg;
   // Test input floats outputs without a clock; the error output stays driven
   assign link.statOe = link.testActN;
   assign link.master_slave_error_output = master_slave_error_output_reg;
endmodule : ddi_device

// ==== rtl/ddi_debugger.sv ====
// Debugger end: APB-programmed sequencer that halts, injects and steps instructions, and resumes.
// Assumes a 32-bit APB master on clk_sys; the link status pins arrive from another device.
//
// Our own choices: the register addresses and the APB register port.
module ddi_debugger
   import ddi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   ddi_link_if.dbg link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef enum {H_IDLE, H_HALT, H_ENTER, H_LOAD, H_TOSTEP, H_GO, H_BACK, H_RESHALT, H_RESGO} ddi_dbg_state_t;

   logic [STAT_W-1:0] statS1_reg, statS2_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         statS1_reg <= STAT_EXEC;
         statS2_reg <= STAT_EXEC;
      end else if (ce) begin
         statS1_reg <= link.stat;
         statS2_reg <= statS1_reg;
      end
   end

   ddi_dbg_state_t st_reg, st_next;
   logic [MODE_W-1:0] mode_reg, mode_next;
   logic [INSTR_W-1:0] instr_reg, instr_next;
   logic [DATA_W-1:0] ldata_reg, ldata_next;
   logic instrOe_reg, instrOe_next;
   logic dataOe_reg, dataOe_next;
   logic testOn_reg, testOn_next;
   logic ldrv_reg, ldrv_next;
   logic halted_reg, halted_next;
   logic refused_reg, refused_next;
   logic seenLast_reg, seenLast_next;
   logic [LOAD_CNT_W-1:0] cnt_reg, cnt_next;
   logic [31:0] rdata_reg, rdata_next;
   logic err_reg, err_next;
   logic access, wr, busy;
   logic [CTRL_CMD_W-1:0] cmd;

   always_comb begin
      st_next = st_reg;
      mode_next = mode_reg;
      instr_next = instr_reg;
      ldata_next = ldata_reg;
      instrOe_next = instrOe_reg;
      dataOe_next = dataOe_reg;
      testOn_next = testOn_reg;
      ldrv_next = ldrv_reg;
      halted_next = halted_reg;
      refused_next = refused_reg;
      seenLast_next = seenLast_reg;
      cnt_next = cnt_reg;
      rdata_next = rdata_reg;
      err_next = 1'b0;
      access = psel && !penable;
      wr = access && pwrite;
      busy = (st_reg != H_IDLE);
      cmd = CMD_NONE;
      if (access) begin
         unique case (paddr)
            ADDR_CTRL: rdata_next = {26'h0, ldrv_reg, testOn_reg, 4'h0};
            ADDR_INSTR: rdata_next = instr_reg;
            ADDR_LDATA: rdata_next = ldata_reg;
            ADDR_STATUS: rdata_next = {25'h0, statS2_reg, 1'b0, refused_reg, halted_reg, busy};
            default: begin
               rdata_next = 32'h0000_0000;
               err_next = 1'b1;
            end
         endcase
      end
      if (wr) begin
         unique case (paddr)
            ADDR_CTRL: begin
               cmd = pwdata[CTRL_CMD_LSB +: CTRL_CMD_W];
               testOn_next = pwdata[CTRL_TEST_BIT];
               ldrv_next = pwdata[CTRL_LDRV_BIT];
            end
            ADDR_INSTR: instr_next = pwdata[INSTR_W-1:0];
            ADDR_LDATA: ldata_next = pwdata[DATA_W-1:0];
            default: ;
         endcase
      end
      unique case (st_reg)
         H_IDLE: begin
            if (cmd == CMD_HALT) begin
               refused_next = 1'b0;
               mode_next = MODE_HALT;
               st_next = H_HALT;
            end else if (cmd == CMD_INJECT_STEP) begin
               // Injection only from halt or step
               if (halted_reg) begin
                  refused_next = 1'b0;
                  mode_next = MODE_INJECT;
                  st_next = H_ENTER;
               end else begin
                  refused_next = 1'b1;
               end
            end else if (cmd == CMD_RESUME) begin
               refused_next = 1'b0;
               mode_next = MODE_HALT;
               st_next = H_RESHALT;
            end
         end
         H_HALT: begin
            if (statS2_reg == STAT_HALTSTEP) begin
               halted_next = 1'b1;
               st_next = H_IDLE;
            end
         end
         H_ENTER: begin
            if (statS2_reg == STAT_INJECT) begin
               instrOe_next = 1'b1;
               cnt_next = LOAD_CNT_W'(LOAD_CYC);
               st_next = H_LOAD;
            end
         end
         H_LOAD: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 1'b1;
            end else begin
               mode_next = MODE_STEP;
               st_next = H_TOSTEP;
            end
         end
         H_TOSTEP: begin
            if (statS2_reg == STAT_HALTSTEP) begin
               instrOe_next = 1'b0;
               dataOe_next = ldrv_reg;
               seenLast_next = 1'b0;
               mode_next = MODE_NORMAL;
               st_next = H_GO;
            end
         end
         H_GO: begin
            if (statS2_reg[STAT_LAST_BIT]) begin
               seenLast_next = 1'b1;
            end
            if (seenLast_reg && statS2_reg == STAT_HALTSTEP) begin
               dataOe_next = 1'b0;
               mode_next = MODE_STEP;
               st_next = H_BACK;
            end
         end
         H_BACK: begin
            st_next = H_IDLE;
         end
         H_RESHALT: begin
            if (statS2_reg == STAT_HALTSTEP) begin
               mode_next = MODE_NORMAL;
               st_next = H_RESGO;
            end
         end
         H_RESGO: begin
            if (statS2_reg == STAT_EXEC) begin
               halted_next = 1'b0;
               st_next = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg <= H_IDLE;
         mode_reg <= MODE_NORMAL;
         instr_reg <= INSTR_RESET;
         ldata_reg <= DATA_RESET;
         instrOe_reg <= 1'b0;
         dataOe_reg <= 1'b0;
         testOn_reg <= 1'b0;
         ldrv_reg <= 1'b0;
         halted_reg <= 1'b0;
         refused_reg <= 1'b0;
         seenLast_reg <= 1'b0;
         cnt_reg <= '0;
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
         mode_reg <= mode_next;
         instr_reg <= instr_next;
         ldata_reg <= ldata_next;
         instrOe_reg <= instrOe_next;
         dataOe_reg <= dataOe_next;
         testOn_reg <= testOn_next;
         ldrv_reg <= ldrv_next;
         halted_reg <= halted_next;
         refused_reg <= refused_next;
         seenLast_reg <= seenLast_next;
         cnt_reg <= cnt_next;
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   assign link.modeCtl = mode_reg;
   assign link.instrBus = instr_reg;
   assign link.instrOe = instrOe_reg;
   assign link.hostData = ldata_reg;
   assign link.hostDataOe = dataOe_reg;
   // Test mode only drives testActN, which floats the device status pins; the bench keeps clk_sys running
   assign link.testActN = !testOn_reg;
   assign prdata = rdata_reg;
   assign pready = 1'b1;
   assign pslverr = err_reg;
endmodule : ddi_debugger

// ==== tb/ddi_link_props.sv ====
// Link checker: mode control, status and instruction-bus enable pins.
// Assumes one clock clk_sys and the async active-low reset nrst.
module ddi_link_props
   import ddi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [MODE_W-1:0] modeCtl,
   input wire logic instrOe,
   input wire logic [STAT_W-1:0] stat,
   input wire logic statOe,
   input wire logic testActN
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   property p_enter;
      $changed(modeCtl) && modeCtl == MODE_INJECT |-> ##[2:3] stat == STAT_INJECT;
   endproperty
   a_enter: assert property (p_enter) else $error("inject entry late");
   property p_exit;
      $changed(modeCtl) && $past(modeCtl) == MODE_INJECT |-> (modeCtl == MODE_HALT || modeCtl == MODE_STEP)
         && stat == STAT_INJECT ##1 stat == STAT_INJECT ##[1:2] stat == STAT_HALTSTEP;
   endproperty
   a_exit: assert property (p_exit) else $error("inject exit wrong");
   property p_from;
      $changed(modeCtl) && modeCtl == MODE_INJECT |->
         ($past(modeCtl) == MODE_HALT || $past(modeCtl) == MODE_STEP) && stat == STAT_HALTSTEP;
   endproperty
   a_from: assert property (p_from) else $error("inject not from halt or step");
   property p_step;
      $changed(modeCtl) && modeCtl == MODE_NORMAL && $past(modeCtl) == MODE_STEP |-> ##[2:3] stat == STAT_HOLD;
   endproperty
   a_step: assert property (p_step) else $error("step did not start");
   property p_last;
      stat == STAT_STEPLAST |=> stat == STAT_HALTSTEP [*2];
   endproperty
   a_last: assert property (p_last) else $error("step did not end in step mode");
   property p_resume;
      $changed(modeCtl) && modeCtl == MODE_NORMAL && $past(modeCtl) == MODE_HALT |-> ##[2:3] stat == STAT_EXEC;
   endproperty
   a_resume: assert property (p_resume) else $error("resume late");
   property p_seq;
      $changed(modeCtl) && modeCtl == MODE_NORMAL |-> $past(modeCtl) == MODE_STEP || $past(modeCtl) == MODE_HALT;
   endproperty
   a_seq: assert property (p_seq) else $error("normal not from step or halt");
   property p_waitinj;
      $rose(instrOe) |-> stat == STAT_INJECT;
   endproperty
   a_waitinj: assert property (p_waitinj) else $error("bus driven before inject");
   property p_load;
      $changed(modeCtl) && modeCtl == MODE_STEP && $past(modeCtl) == MODE_INJECT |-> $past(instrOe, 2);
   endproperty
   a_load: assert property (p_load) else $error("step before load");
   property p_float;
      statOe == testActN;
   endproperty
   a_float: assert property (p_float) else $error("status enable not tied to test");
   c_enter: cover property (p_enter);
   c_step: cover property (p_step);
   c_resume: cover property (p_resume);
endmodule : ddi_link_props

// ==== tb/ddi_debug_instruction_injection_test.sv ====
// Bench: debugger and device joined by the link; APB drives the debugger.
// Assumes clk_sys at 200 MHz; the bench acts as core and memory system.
module ddi_debug_instruction_injection_test
   import ddi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0;
   logic nrst = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic burstEst = 0, accBusy = 0, accStart = 0, excData = 0, excCop = 0, excOth = 0, msIn = 0;
   logic [OPT_W-1:0] access_option_code = '0;
   logic [INSTR_W-1:0] irOut;
   logic irValid, pipeAdv, preempt, psrForce, freeze, inhibit, priv, excTake, optDone;
   int preCnt = 0, optCnt = 0, advCnt = 0;
   int errors = 0, checks = 0, cyc = 0;
   logic [31:0] expQ[$];
   ddi_link_if link();
   ddi_device i_ddi_device (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .link(link.dev),
      .burstEstablished(burstEst), .dataAccessBusy(accBusy), .accessStart(accStart), .accessOpt(access_option_code),
      .excDataAccess(excData), .excCoproc(excCop), .excOther(excOth), .msErrIn(msIn), .irOut(irOut),
      .irValid(irValid), .pipeAdvance(pipeAdv), .burstPreempt(preempt), .debugPsrForce(psrForce),
      .stateFreeze(freeze), .specialInhibit(inhibit), .privOverride(priv), .excTake(excTake),
      .optAccessDone(optDone));
   ddi_debugger i_ddi_debugger (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .link(link.dbg), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   ddi_link_props i_ddi_link_props (.clk_sys(clk_sys), .nrst(nrst), .modeCtl(link.modeCtl),
      .instrOe(link.instrOe), .stat(link.stat), .statOe(link.statOe), .testActN(link.testActN));
   always #2.5 clk_sys = ~clk_sys;
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (preempt) preCnt <= preCnt + 1;
      if (optDone) optCnt <= optCnt + 1;
      if (pipeAdv) advCnt <= advCnt + 1;
      if (cyc == 20000) begin
         errors++;
         $display("MISMATCH timeout expected 0 seen 1");
         conclude();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic idle();
      int n;
      n = 0;
      do begin
         apb(0, ADDR_STATUS, 0);
         n++;
      end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 100);
   endtask : idle
   task automatic waitS(input logic [STAT_W-1:0] s);
      int n;
      n = 0;
      while (link.stat !== s && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      chk("stat", s, link.stat);
   endtask : waitS
   task automatic inj(input int k);
      logic [31:0] ins, ld;
      logic ldrv, early;
      int pre0, opt0, adv0;
      ins = $urandom;
      ld = $urandom;
      ldrv = $urandom % 2;
      early = 0;
      accBusy <= (k == 0);
      apb(1, ADDR_CTRL, 32'(CMD_HALT));
      repeat (6) @(posedge clk_sys);
      if (k == 0) chk("haltWait", STAT_EXEC, link.stat);
      accBusy <= 0;
      idle();
      access_option_code <= (k == 2) ? OPT_DEBUGGER : 3'(1 + $urandom % 5);
      excOth <= (k == 0);
      excData <= (k == 1);
      excCop <= (k == 2);
      accStart <= (k == 1 || k == 2);
      burstEst <= $urandom % 2;
      pre0 = preCnt;
      opt0 = optCnt;
      adv0 = advCnt;
      expQ.push_back(ins);
      apb(1, ADDR_INSTR, ins);
      apb(1, ADDR_LDATA, ld);
      apb(1, ADDR_CTRL, 32'(CMD_INJECT_STEP) | (32'(ldrv) << CTRL_LDRV_BIT));
      waitS(STAT_INJECT);
      repeat (2) @(posedge clk_sys);
      chk("psrForce", 1, psrForce);
      chk("freeze", 1, freeze);
      chk("inhibit", 1, inhibit);
      chk("priv", 1, priv);
      chk("excTake", k == 1, excTake);
      chk("preempt", 32'(burstEst), 32'(preCnt - pre0));
      excOth <= 0;
      excData <= 0;
      excCop <= 0;
      waitS(STAT_HALTSTEP);
      chk("irOut", expQ.pop_front(), irOut);
      chk("irValid", 1, irValid);
      chk("freezeOff", 0, freeze);
      chk("psrHeld", 1, psrForce);
      waitS(STAT_HOLD);
      chk("loadOe", ldrv, link.hostDataOe);
      if (ldrv) chk("loadData", ld, link.hostData);
      if (k == 1) begin
         repeat (2 + $urandom % 8) begin
            @(posedge clk_sys);
            if (link.stat === STAT_STEPLAST) early = 1;
         end
         link.dataRdy <= 1;
      end
      waitS(STAT_STEPLAST);
      accStart <= 0;
      chk("early", 0, early);
      chk("optDone", 32'(k == 3), 32'(optCnt - opt0));
      chk("advance", 1, 32'(advCnt - adv0));
      waitS(STAT_HALTSTEP);
      link.dataRdy <= 0;
      idle();
      $display("test inject %0d done", k);
   endtask : inj
   initial begin
      void'($urandom(32'h5d24));
      link.dataRdy = 0;
      link.dataErr = 0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1;
      for (int k = 0; k < 4; k++) inj(k);
      apb(1, ADDR_CTRL, 32'(CMD_RESUME));
      idle();
      waitS(STAT_EXEC);
      chk("psrForce", 0, psrForce);
      apb(1, ADDR_CTRL, 32'(CMD_INJECT_STEP));
      idle();
      chk("refused", 1, rd[STATUS_REFUSED_BIT]);
      chk("stat", STAT_EXEC, link.stat);
      apb(0, 4'h2, 32'h0);
      chk("slverr", 1, se);
      chk("rdata", 0, rd);
      $display("test resume done");
      msIn <= 1;
      apb(1, ADDR_CTRL, 32'h1 << CTRL_TEST_BIT);
      repeat (2) @(posedge clk_sys);
      chk("statOe", 0, link.statOe);
      chk("master_slave_error_output", 1, link.master_slave_error_output);
      apb(1, ADDR_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("statOe", 1, link.statOe);
      $display("test float done");
      conclude();
   end
endmodule : ddi_debug_instruction_injection_test
